// >>> rtl/mcc_top.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Overview of operation
// - Clock-out bit set routes the system clock to the output pin.
// - Pin carries no clock in sleep unless a peripheral uses it.
// - Source field picks fast, low-power, crystal or external clock.
// - Prescaler on: divider codes give 2..64 and 6,10,12,24,48.
// - Prescaler off passes the main clock undivided.
// - Divider field may be rewritten at any time until frozen.
// - Freeze bit blocks source, prescaler and active calibration.
// - Once frozen, the freeze register ignores accesses until reset.
// - Freeze bit takes its first value from the fuse.
// - External started flag rises once the input runs; resets low.
// - Stability flags except external read one only while requested and stable; external reads the sticky started flag.
// - Switch flag stays high until the new source takes over.
// - Keep-running bit holds the fast oscillator powered.
// - Fast oscillator gate stays shut unless something requests it.
// - Gate opens four edges after request; start-up skipped if kept.
// - Fine trim loads factory value chosen by fuse frequency choice.
// - Slope field writable, lock flag read-only; lock blocks trims.
// - Calibration lock flag loads from the fuse at reset.
// - Protected writes need the unlock key within four instructions.
// - A protected write without unlock leaves the register alone.
// - Crystal select and start-up locked while enabled or stable.
// ------------------------------------------------------------
module mcc_top #(
	parameter logic [31:0] TRIM_TAB  = 32'h40404040, // Arbitrary trims
	parameter logic [15:0] SLOPE_TAB = 16'h8888      // Arbitrary slopes
) (
	input  wire logic                   mclk,         // System clock
	input  wire logic                   arst_n,       // Async reset
	input  wire logic                   ce,           // Clock enable
	input  wire logic [mcc_pkg::AW-1:0] addr,         // Register offset
	input  wire logic [mcc_pkg::DW-1:0] wdata,        // Write data
	input  wire logic                   wr,           // Write strobe
	input  wire logic                   rd,           // Read strobe
	output var  logic [mcc_pkg::DW-1:0] rdata,        // Read data
	input  wire logic                   unlock_key,   // Key written
	input  wire logic                   instr_done,   // One instr
	input  wire logic [3:0]             osc_in,       // Source levels
	input  wire logic                   fast_ready,   // Analog up
	input  wire logic                   ulp_ready,    // ULP stable
	input  wire logic                   xtl_ready,    // Crystal up
	input  wire logic [3:0]             periph_req,   // Source req
	input  wire logic                   sleeping,     // Device asleep
	input  wire logic                   per_uses_sys, // Sys clk in use
	input  wire logic                   fuse_trim_lock,   // Fuse lock
	input  wire logic [1:0]             fuse_freq_choice, // Fuse freq
	output var  logic                   main_clk,         // Main clk
	output var  logic                   peripheral_clock, // Prescaled
	output var  logic                   sysclk_pin_drive, // Pin out
	output var  logic                   fast_osc_run,     // Osc power
	output var  logic                   fast_gate,        // Gate open
	output var  logic [7:0]             fast_trim,        // Fine trim
	output var  logic [3:0]             temp_slope_trim,  // Slope
	output var  logic                   crystal_run       // Crystal on
);
	import mcc_pkg::*;

	mcc_st_s    q;
	mcc_st_s    d;
	logic [3:0] lvl;
	logic [3:0] rise;
	logic [3:0] req;
	logic [3:0] stab;
	logic       sw_busy;
	logic       xtl_s;
	logic       ok;
	logic       unfrz;
	logic       cal_ok;

	mcc_div_if u_if ();

	// ------------------------------------------------------------
	// Requests and stability per source
	// ------------------------------------------------------------
	assign sw_busy = (q.sw == SW_WAIT);

	// Pending target counts as a request so it can start up
	for (genvar g = 0; g < 4; g++) begin : g_req
		assign req[g] = periph_req[g] | (q.act == 2'(g))
			| (sw_busy && q.src_req == 2'(g));
	end

	// Fast level only seen through its gate
	assign lvl  = {osc_in[3:1], osc_in[0] & q.gate};
	assign rise = osc_in & ~q.prev;
	assign xtl_s = req[SRC_XTL] & q.xen & xtl_ready;
	assign stab = {q.ext_on, xtl_s, req[SRC_ULP] & ulp_ready,
		req[SRC_FAST] & q.gate};

	// ------------------------------------------------------------
	// Write qualification
	// ------------------------------------------------------------
	assign ok     = ce & wr & q.init & (q.win != 3'h0);
	assign unfrz  = ok & !q.frz;
	assign cal_ok = ok & !q.tlock
		& !(q.frz && q.act == SRC_FAST);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		d.prev = osc_in;

		// Unlock window counts retired instructions
		if (unlock_key) begin
			d.win = UNLOCK_INSTR;
		end else if (instr_done && q.win != 3'h0) begin
			d.win = q.win - 3'h1;
		end

		// Fuse values caught on the first edge after reset release
		if (!q.init) begin
			d.init   = 1'b1;
			d.frz    = fuse_trim_lock;
			d.tlock  = fuse_trim_lock;
			d.trim   = TRIM_TAB[{fuse_freq_choice, 3'h0} +: 8];
			d.tslope = SLOPE_TAB[{fuse_freq_choice, 2'h0} +: 4];
		end

		// Fast gate: four oscillator edges after request
		if (!req[SRC_FAST]) begin
			d.gate = 1'b0;
			d.fcnt = 2'h0;
		end else if (!q.gate && (fast_ready || q.keep_f)
			&& rise[SRC_FAST]) begin
			if (q.fcnt == FAST_GATE_CYC) begin
				d.gate = 1'b1;
			end else begin
				d.fcnt = q.fcnt + 2'h1;
			end
		end

		// External input counts two edges once requested
		if (!q.ext_on && req[SRC_EXT] && rise[SRC_EXT]) begin
			if (q.ecnt == EXT_START_CYC) begin
				d.ext_on = 1'b1;
			end else begin
				d.ecnt = q.ecnt + 2'h1;
			end
		end

		// Handover only when both clocks sit low: no runt pulse
		case (q.sw)
			SW_IDLE: begin
				d.sw = SW_IDLE;
			end
			SW_WAIT: begin
				if (stab[q.src_req] && !lvl[q.act]
					&& !lvl[q.src_req]) begin
					d.act = q.src_req;
					d.sw  = SW_IDLE;
				end
			end
			default: begin
				d.sw = SW_IDLE;
			end
		endcase

		// Register writes
		if (unfrz && addr == A_SRC) begin
			d.pin_en  = wdata[B_PIN_EN];
			d.src_req = mcc_src_e'(wdata[1:0]);
			d.sw = (wdata[1:0] == q.act) ? SW_IDLE : SW_WAIT;
		end
		if (unfrz && addr == A_PRE) begin
			d.prescaler_on = wdata[B_PEN];
			if (mcc_half(wdata[4:1]) != 6'h00) begin
				d.div_code = wdata[4:1];
			end
		end
		if (unfrz && addr == A_FRZ && wdata[0]) begin
			d.frz = 1'b1;
		end
		if (ok && addr == A_FCTL) begin
			d.keep_f = wdata[B_KEEP];
		end
		if (cal_ok && addr == A_TRIM) begin
			d.trim = wdata;
		end
		if (cal_ok && addr == A_TEMP) begin
			d.tslope = wdata[3:0];
		end
		if (ok && addr == A_ULP) begin
			d.keep_u = wdata[B_KEEP];
		end
		if (ok && addr == A_XTL) begin
			d.xen   = wdata[B_XEN];
			d.xkeep = wdata[B_KEEP];
			if (!q.xen && !xtl_s) begin
				d.xsel = wdata[B_XSEL];
				d.xstart = wdata[5:4];
			end
		end

		// Registered outputs
		d.main = lvl[q.act];
		d.pin  = q.pin_en & (!sleeping | per_uses_sys)
			& lvl[q.act];
		d.frun = req[SRC_FAST] | q.keep_f;
		d.xrun = q.xen & (q.xkeep | req[SRC_XTL]);

		// Read data stands for one cycle only
		d.rdata = 8'h00;
		if (rd) begin
			case (addr)
				A_SRC:  d.rdata = {q.pin_en, 5'h00, q.src_req};
				A_PRE:  d.rdata = {3'h0, q.div_code, q.prescaler_on};
				A_FRZ:  d.rdata = 8'h00;
				A_STAT: d.rdata = {stab, 3'h0, sw_busy};
				A_FCTL: d.rdata = {6'h00, q.keep_f, 1'b0};
				A_TRIM: d.rdata = q.trim;
				A_TEMP: d.rdata = {q.tlock, 3'h0, q.tslope};
				A_ULP:  d.rdata = {6'h00, q.keep_u, 1'b0};
				A_XTL:  d.rdata = {2'h0, q.xstart, 1'b0, q.xsel,
					q.xkeep, q.xen};
				default: d.rdata = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			q <= ST_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	// Prescaler runs from the selected main clock level
	assign u_if.main_lvl = q.main;
	assign u_if.prescaler_on      = q.prescaler_on;
	assign u_if.half     = mcc_half(q.div_code);

	mcc_div u_div (
		.mclk   (mclk),
		.arst_n (arst_n),
		.ce     (ce),
		.dv     (u_if.div)
	);

	// ------------------------------------------------------------
	// Output wiring, all from flip-flops
	// ------------------------------------------------------------
	assign rdata            = q.rdata;
	assign main_clk         = q.main;
	assign peripheral_clock = u_if.per_clk;
	assign sysclk_pin_drive = q.pin;
	assign fast_osc_run     = q.frun;
	assign fast_gate        = q.gate;
	assign fast_trim        = q.trim;
	assign temp_slope_trim  = q.tslope;
	assign crystal_run      = q.xrun;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	property p_pin_en;
		ce && !q.pin_en |=> !sysclk_pin_drive;
	endproperty
	a_pin_en: assert property (p_pin_en) else $error("pin w/o enable");
	property p_pin_sleep;
		ce && sleeping && !per_uses_sys |=> !sysclk_pin_drive;
	endproperty
	a_pin_sleep: assert property (p_pin_sleep) else $error("pin asleep");
	property p_main;
		ce |=> main_clk == $past(lvl[q.act]);
	endproperty
	a_main: assert property (p_main) else $error("main mismatch");
	property p_divc;
		unfrz && addr == A_PRE && mcc_half(wdata[4:1]) != 6'h00
			|=> q.div_code == $past(wdata[4:1]);
	endproperty
	a_divc: assert property (p_divc) else $error("div lost");
	property p_frz;
		ce && q.frz && wr && addr == A_SRC |=> $stable(q.src_req);
	endproperty
	a_frz: assert property (p_frz) else $error("frozen src moved");
	property p_frz_hold;
		q.init && q.frz |=> q.frz;
	endproperty
	a_frz_hold: assert property (p_frz_hold) else $error("freeze left");
	property p_fuse;
		ce && arst_n && !q.init |=> q.frz == $past(fuse_trim_lock)
			&& q.tlock == $past(fuse_trim_lock);
	endproperty
	a_fuse: assert property (p_fuse) else $error("fuse not loaded");
	property p_ext_on;
		q.ext_on |=> q.ext_on;
	endproperty
	a_ext_on: assert property (p_ext_on) else $error("ext flag fell");
	property p_stat;
		ce && rd && addr == A_STAT && !req[SRC_FAST] |=> !rdata[4];
	endproperty
	a_stat: assert property (p_stat) else $error("unreq stable");
	property p_switch_in_progress;
		ce && rd && addr == A_STAT |=> rdata[0] == $past(sw_busy);
	endproperty
	a_switch_in_progress: assert property (p_switch_in_progress) else $error("switch flag");
	property p_keep;
		ce && q.keep_f |=> fast_osc_run;
	endproperty
	a_keep: assert property (p_keep) else $error("osc stopped");
	property p_gate_req;
		ce && !req[SRC_FAST] |=> !fast_gate;
	endproperty
	a_gate_req: assert property (p_gate_req) else $error("gate open");
	property p_gate4;
		$rose(fast_gate) |-> $past(q.fcnt) == 2'h3;
	endproperty
	a_gate4: assert property (p_gate4) else $error("gate early");
	property p_tlock;
		ce && q.tlock && wr |=> $stable(q.trim) && $stable(q.tslope);
	endproperty
	a_tlock: assert property (p_tlock) else $error("trim moved");
	property p_unlock;
		ce && unlock_key |=> q.win == 3'h4;
	endproperty
	a_unlock: assert property (p_unlock) else $error("no window");
	property p_locked;
		ce && wr && q.win == 3'h0
			|=> $stable(q.div_code) && $stable(q.prescaler_on);
	endproperty
	a_locked: assert property (p_locked) else $error("write leaked");
	property p_xtl;
		ce && wr && (q.xen || xtl_s)
			|=> $stable(q.xsel) && $stable(q.xstart);
	endproperty
	a_xtl: assert property (p_xtl) else $error("crystal cfg moved");
	property p_hand;
		ce && q.act != d.act |-> sw_busy && !lvl[q.act];
	endproperty
	a_hand: assert property (p_hand) else $error("bad handover");

	c_switch: cover property (sw_busy ##1 !sw_busy);
	c_frz: cover property (ce && unfrz && addr == A_FRZ && wdata[0]);
	c_pin: cover property (sysclk_pin_drive);
endmodule
`default_nettype wire

// >>> shared/mcc_pkg.sv
package mcc_pkg;
	// ------------------------------------------------------------
	// Widths and register offsets
	// ------------------------------------------------------------
	localparam int          AW     = 5;
	localparam int          DW     = 8;
	localparam logic [4:0]  A_SRC  = 5'h00;
	localparam logic [4:0]  A_PRE  = 5'h01;
	localparam logic [4:0]  A_FRZ  = 5'h02;
	localparam logic [4:0]  A_STAT = 5'h03;
	localparam logic [4:0]  A_FCTL = 5'h10;
	localparam logic [4:0]  A_TRIM = 5'h11;
	localparam logic [4:0]  A_TEMP = 5'h12;
	localparam logic [4:0]  A_ULP  = 5'h18;
	localparam logic [4:0]  A_XTL  = 5'h1c;
	// ------------------------------------------------------------
	// Field positions, reset values, counts
	// ------------------------------------------------------------
	localparam int          B_PIN_EN = 7;
	localparam int          B_PEN    = 0;
	localparam int          B_KEEP   = 1;
	localparam int          B_XEN    = 0;
	localparam int          B_XSEL   = 2;
	localparam logic [7:0]  R_PRE    = 8'h11;
	localparam logic [1:0]  FAST_GATE_CYC = 2'h3; // Four edges, 0..3
	localparam logic [1:0]  EXT_START_CYC = 2'h1; // Two edges, 0..1
	localparam logic [2:0]  UNLOCK_INSTR  = 3'h4;

	typedef enum logic [1:0] {
		SRC_FAST = 2'b00,
		SRC_ULP  = 2'b01,
		SRC_XTL  = 2'b10,
		SRC_EXT  = 2'b11
	} mcc_src_e;

	typedef enum logic {
		SW_IDLE = 1'b0,
		SW_WAIT = 1'b1
	} mcc_sw_e;

	typedef struct packed {
		logic       init;
		logic [2:0] win;
		logic       pin_en;
		mcc_src_e   src_req;
		mcc_src_e   act;
		mcc_sw_e    sw;
		logic [3:0] div_code;
		logic       prescaler_on;
		logic       frz;
		logic       keep_f;
		logic       keep_u;
		logic [7:0] trim;
		logic [3:0] tslope;
		logic       tlock;
		logic       xen;
		logic       xkeep;
		logic       xsel;
		logic [1:0] xstart;
		logic [3:0] prev;
		logic [1:0] fcnt;
		logic       gate;
		logic [1:0] ecnt;
		logic       ext_on;
		logic       main;
		logic       pin;
		logic       frun;
		logic       xrun;
		logic [7:0] rdata;
	} mcc_st_s;

	// Everything zero except the prescaler defaults
	localparam mcc_st_s ST_RST = '{div_code: R_PRE[4:1], prescaler_on: R_PRE[0],
		src_req: SRC_FAST, act: SRC_FAST, sw: SW_IDLE, default: '0};

	// Half of the division ratio; zero marks a reserved code
	function automatic logic [5:0] mcc_half(input logic [3:0] c);
		case (c)
			4'h0: mcc_half = 6'h01;
			4'h1: mcc_half = 6'h02;
			4'h2: mcc_half = 6'h04;
			4'h3: mcc_half = 6'h08;
			4'h4: mcc_half = 6'h10;
			4'h5: mcc_half = 6'h20;
			4'h8: mcc_half = 6'h03;
			4'h9: mcc_half = 6'h05;
			4'ha: mcc_half = 6'h06;
			4'hb: mcc_half = 6'h0c;
			4'hc: mcc_half = 6'h18;
			default: mcc_half = 6'h00;
		endcase
	endfunction
endpackage

// >>> shared/mcc_div_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mcc_div_if;
	logic       main_lvl;
	logic       prescaler_on;
	logic [5:0] half;
	logic       per_clk;
	modport ctl (output main_lvl, prescaler_on, half, input per_clk);
	modport div (input main_lvl, prescaler_on, half, output per_clk);
endinterface
`default_nettype wire

// >>> rtl/mcc_div.sv
`timescale 1ns/1ps
`default_nettype none
module mcc_div (
	input  wire logic mclk,   // System clock
	input  wire logic arst_n, // Async reset, low
	input  wire logic ce,     // Clock enable
	mcc_div_if.div    dv      // Prescaler link
);
	import mcc_pkg::*;

	typedef struct packed {
		logic [5:0] cnt;
		logic       prev;
		logic       per;
	} mcc_dv_s;

	mcc_dv_s q;
	mcc_dv_s d;

	// ------------------------------------------------------------
	// Even divider: toggle every half ratio of main rising edges
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		d.prev = dv.main_lvl;
		if (!dv.prescaler_on) begin
			d.per = dv.main_lvl;
			d.cnt = 6'h00;
		end else if (dv.main_lvl && !q.prev) begin
			if (q.cnt + 6'h01 >= dv.half) begin
				d.cnt = 6'h00;
				d.per = !q.per;
			end else begin
				d.cnt = q.cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign dv.per_clk = q.per;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	property p_pass;
		ce && !dv.prescaler_on |=> dv.per_clk == $past(dv.main_lvl);
	endproperty
	a_pass: assert property (p_pass) else $error("bypass lost");
	property p_wrap;
		ce && dv.prescaler_on && dv.main_lvl && !q.prev && q.cnt + 6'h01 >= dv.half
			|=> dv.per_clk != $past(dv.per_clk);
	endproperty
	a_wrap: assert property (p_wrap) else $error("no toggle");
	c_div: cover property (ce && dv.prescaler_on && dv.half == 6'h03 && d.per != q.per);
endmodule
`default_nettype wire

// >>> testbench/mcc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mcc_top_tb;
	import mcc_pkg::*;
	// ------------------------------------------------------------
	// Bench signals, named as the ports except cyc, which drives osc_in
	// ------------------------------------------------------------
	logic       mclk = 1'b0;
	logic       arst_n = 1'b0;
	logic       ce = 1'b1;
	logic [4:0] addr = '0;
	logic [7:0] wdata = '0;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] rdata;
	logic       unlock_key = 1'b0;
	logic       instr_done = 1'b0;
	logic [3:0] cyc = '0;
	logic       fast_ready = 1'b0;
	logic       ulp_ready = 1'b0;
	logic       xtl_ready = 1'b0;
	logic [3:0] periph_req = '0;
	logic       sleeping = 1'b0;
	logic       per_uses_sys = 1'b0;
	logic       fuse_trim_lock = 1'b0;
	logic [1:0] fuse_freq_choice = 2'h0;
	logic       main_clk, peripheral_clock, sysclk_pin_drive;
	logic       fast_osc_run, fast_gate, crystal_run;
	logic [7:0] fast_trim, d;
	logic [3:0] temp_slope_trim;
	int         bad_count = 0;
	int         checks = 0;
	int         tmo = 0;
	int         p;
	logic [3:0] cd [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
		4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
	int         rt [11] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48};
	logic [7:0] st [4] = '{8'h90, 8'h20, 8'h40, 8'h80};

	mcc_top uut (.mclk, .arst_n, .ce, .addr, .wdata, .wr, .rd, .rdata,
		.unlock_key, .instr_done, .osc_in(cyc), .fast_ready, .ulp_ready,
		.xtl_ready, .periph_req, .sleeping, .per_uses_sys,
		.fuse_trim_lock, .fuse_freq_choice, .main_clk, .peripheral_clock,
		.sysclk_pin_drive, .fast_osc_run, .fast_gate, .fast_trim,
		.temp_slope_trim, .crystal_run);

	// Clock; source levels: bit i has a period of 2^(i+1) cycles
	always #4 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 4'h1;

	// Hang guard, well above the expected run length
	always @(posedge mclk) begin
		tmo++;
		if (tmo == 20000) begin
			bad_count++;
			end_of_test();
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] s, e);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic rst(input logic fl);
		arst_n <= 1'b0;
		fuse_trim_lock <= fl;
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (2) @(posedge mclk);
	endtask

	task automatic wreg(input logic [4:0] a, input logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [4:0] a, output logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	// One-cycle pulse: 0 unlock key, 1 instruction retired
	task automatic pulse(input int w);
		@(posedge mclk);
		if (w == 0) unlock_key <= 1'b1;
		else instr_done <= 1'b1;
		@(posedge mclk);
		unlock_key <= 1'b0;
		instr_done <= 1'b0;
	endtask

	// Protected write: key first, write two edges later
	task automatic pw(input logic [4:0] a, input logic [7:0] v);
		pulse(0);
		wreg(a, v);
	endtask

	task automatic rchk(input string n, input logic [4:0] a,
		input logic [7:0] e);
		rreg(a, d);
		chk(n, d, e);
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: pick = sysclk_pin_drive;
			1: pick = peripheral_clock;
			default: pick = main_clk;
		endcase
	endfunction

	// Period in cycles, first period skipped as it may be transitional
	task automatic pchk(input string nm, input int s, input int e);
		int n, r, r0;
		logic pv, cv;
		p = 0;
		r = 0;
		n = 0;
		r0 = 0;
		pv = pick(s);
		while (r < 3 && n < 600) begin
			@(posedge mclk);
			#1 cv = pick(s);
			n++;
			if (cv && !pv) begin
				r++;
				if (r == 2) r0 = n;
				if (r == 3) p = n - r0;
			end
			pv = cv;
		end
		chk(nm, 8'(p), 8'(e));
	endtask

	// Poll the switch flag under a bound
	task automatic wait_sw;
		int k;
		k = 0;
		d = 8'h01;
		while (d[0] === 1'b1 && k < 200) begin
			rreg(A_STAT, d);
			k++;
		end
		chk("switch done", 8'(d[0]), 8'h00);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst(1'b0);
		rchk("src rst", A_SRC, 8'h00);
		rchk("pre rst", A_PRE, 8'h11);
		rchk("frz rst", A_FRZ, 8'h00);
		rchk("stat rst", A_STAT, 8'h00);
		rchk("fctl rst", A_FCTL, 8'h00);
		rchk("trim rst", A_TRIM, 8'h40);
		rchk("temp rst", A_TEMP, 8'h08);
		rchk("unmapped", 5'h05, 8'h00);
		// Window closed, expired, then just open enough
		wreg(A_PRE, 8'h03);
		rchk("no key", A_PRE, 8'h11);
		pulse(0);
		repeat (4) pulse(1);
		wreg(A_PRE, 8'h03);
		rchk("late write", A_PRE, 8'h11);
		pulse(0);
		repeat (3) pulse(1);
		wreg(A_PRE, 8'h03);
		rchk("in window", A_PRE, 8'h03);
		// Clock enable low must swallow an otherwise valid write
		ce <= 1'b0;
		wreg(A_PRE, 8'h05);
		ce <= 1'b1;
		rchk("ce frozen", A_PRE, 8'h03);
		fast_ready <= 1'b1;
		// Every divider code, rewritten at run time
		for (int i = 0; i < 11; i++) begin
			pw(A_PRE, {3'h0, cd[i], 1'b1});
			pchk("per div", 1, 2 * rt[i]);
		end
		pw(A_PRE, 8'h0d);
		rchk("reserved", A_PRE, 8'h19);
		pchk("per kept", 1, 96);
		pw(A_PRE, 8'h0a);
		pchk("per bypass", 1, 2);
		// Clock out pin, also in sleep
		pw(A_SRC, 8'h80);
		pchk("pin on", 0, 2);
		sleeping <= 1'b1;
		pchk("pin sleep", 0, 0);
		per_uses_sys <= 1'b1;
		pchk("pin sleep used", 0, 2);
		sleeping <= 1'b0;
		per_uses_sys <= 1'b0;
		pw(A_SRC, 8'h00);
		pchk("pin off", 0, 0);
		// Calibration before any lock
		pw(A_TRIM, 8'h5a);
		rchk("trim wr", A_TRIM, 8'h5a);
		chk("trim out", fast_trim, 8'h5a);
		pw(A_TEMP, 8'h85);
		rchk("temp wr", A_TEMP, 8'h05);
		chk("slope out", 8'(temp_slope_trim), 8'h05);
		// Crystal select and start-up only while disabled
		pw(A_XTL, 8'h34);
		rchk("xtl cfg", A_XTL, 8'h34);
		chk("xtl idle", 8'(crystal_run), 8'h00);
		pw(A_XTL, 8'h35);
		pw(A_XTL, 8'h01);
		rchk("xtl held", A_XTL, 8'h35);
		pw(A_XTL, 8'h04);
		rchk("xtl off", A_XTL, 8'h34);
		pw(A_XTL, 8'h01);
		rchk("xtl free", A_XTL, 8'h01);
		// Source switching through all four sources
		pw(A_FCTL, 8'h02);
		for (int j = 1; j < 5; j++) begin
			pw(A_SRC, 8'(j % 4));
			rreg(A_STAT, d);
			chk("switching", 8'(d[0]), 8'h01);
			if (j == 1) ulp_ready <= 1'b1;
			if (j == 2) xtl_ready <= 1'b1;
			wait_sw();
			pchk("main period", 2, 2 << (j % 4));
			rchk("status", A_STAT, st[j % 4]);
			if (j == 2) chk("xtl run", 8'(crystal_run), 8'h01);
			if (j == 1) begin
				chk("keep run", 8'(fast_osc_run), 8'h01);
				pw(A_FCTL, 8'h00);
				@(posedge mclk);
				#1 chk("keep off", 8'(fast_osc_run), 8'h00);
				chk("gate shut", 8'(fast_gate), 8'h00);
				periph_req <= 4'h1;
				@(posedge mclk);
				#1 chk("gate early", 8'(fast_gate), 8'h00);
				repeat (12) @(posedge mclk);
				#1 chk("gate open", 8'(fast_gate), 8'h01);
				periph_req <= 4'h0;
				repeat (2) @(posedge mclk);
				#1 chk("gate drop", 8'(fast_gate), 8'h00);
			end
		end
		// Freeze until reset
		pw(A_FRZ, 8'h01);
		pw(A_PRE, 8'h03);
		rchk("pre frozen", A_PRE, 8'h0a);
		pw(A_SRC, 8'h01);
		rchk("src frozen", A_SRC, 8'h00);
		rchk("frz read", A_FRZ, 8'h00);
		pw(A_TRIM, 8'h33);
		rchk("trim frozen", A_TRIM, 8'h5a);
		// Fuse lock set at reset, other table entry chosen
		fuse_freq_choice <= 2'h2;
		rst(1'b1);
		rchk("cal lock", A_TEMP, 8'h88);
		pw(A_TRIM, 8'h33);
		rchk("trim locked", A_TRIM, 8'h40);
		pw(A_PRE, 8'h03);
		rchk("fuse freeze", A_PRE, 8'h11);
		end_of_test();
	end
endmodule
`default_nettype wire
